// ### core/spd_serial_prog.sv
// Serial programming command decoder with its flash, EEPROM and configuration store.
`timescale 1ns/1ps
module spd_serial_prog
	import spd_pkg::*;
#(
	parameter int         FA_W            = 9,
	parameter int         FP_W            = 6,
	parameter int         EA_W            = 10,
	parameter int         EP_W            = 2,
	parameter logic [7:0] SIG0            = 8'h3d, // Arbitrary value.
	parameter logic [7:0] SIG1            = 8'h55, // Arbitrary value.
	parameter logic [7:0] SIG2            = 8'h0a, // Arbitrary value.
	parameter logic [7:0] CAL_BYTE        = 8'h80,
	parameter int         FUSE_WAIT       = FUSE_WAIT_CYC,
	parameter int         FLASH_WAIT      = FLASH_WAIT_CYC,
	parameter int         EEPROM_WAIT     = EEPROM_WAIT_CYC,
	parameter int         ERASE_WAIT      = ERASE_WAIT_CYC
)(
	input  wire logic CLK,
	input  wire logic RST_N,
	input  wire logic CE,
	input  wire logic RESET_PIN_N,
	input  wire logic SCK,
	input  wire logic MOSI,
	output logic      MISO,
	output logic      PROG_ACTIVE,
	output logic      PENDING
);
	logic [2:0]        sck_s, mosi_s, rst_s;
	logic              sck_rise, sck_fall, hold;
	logic [2:0]        bit_reg, bit_next;
	logic [1:0]        byte_reg, byte_next;
	logic [7:0]        rx_reg, rx_next, rx_in, tx_reg, tx_next, resp;
	logic              miso_reg, miso_next, en_reg, en_next;
	logic [7:0]        b1_reg, b1_next, b2_reg, b2_next, b3_reg, b3_next;
	logic [7:0]        ext_reg, ext_next;
	logic [7:0]        lock_reg, lock_next, lf_reg, lf_next, hf_reg, hf_next, ef_reg, ef_next;
	logic [BUSY_W-1:0] busy_reg, busy_next;
	logic              exec, ok, busy, cfg_wr;
	spd_cmd_t          cmd;
	logic              do_erase, do_ld_hi, do_ld_lo, do_ee_ld, do_pg_wr, do_ee_wr, do_ee_pg;
	logic [23:0]       fa_cmd, fa_rd;
	logic [15:0]       ea_cmd;
	logic [15:0]       flash [2**FA_W];
	logic [15:0]       pbuf [2**FP_W];
	logic [7:0]        eeprom [2**EA_W];
	logic [7:0]        ebuf [2**EP_W];
	logic [2**EP_W-1:0] evld;

	// Pins are asynchronous; the edge detectors only look at the second stage onward.
	always_ff @(posedge CLK or negedge RST_N)
		if (!RST_N)
		begin
			sck_s  <= 3'h0;
			mosi_s <= 3'h0;
			rst_s  <= 3'h7;
		end
		else if (CE)
		begin
			sck_s  <= {sck_s[1:0], SCK};
			mosi_s <= {mosi_s[1:0], MOSI};
			rst_s  <= {rst_s[1:0], RESET_PIN_N};
		end

	assign sck_rise = sck_s[1] & ~sck_s[2];
	assign sck_fall = ~sck_s[1] & sck_s[2];
	assign hold     = ~rst_s[2];
	assign rx_in    = {rx_reg[6:0], mosi_s[2]}; // RL21
	assign exec     = hold && sck_rise && bit_reg == LAST_BIT && byte_reg == LAST_BYTE; // RL1
	assign cmd      = '{op: b1_reg, a_hi: b2_reg, a_lo: b3_reg, data: rx_in};
	assign busy     = busy_reg != '0;
	assign ok       = en_reg && !busy;
	assign fa_cmd   = {ext_reg, b2_reg, b3_reg};
	assign fa_rd    = {ext_reg, b2_reg, rx_in};
	assign ea_cmd   = {cmd.a_hi, cmd.a_lo};

	assign do_erase = exec && ok && cmd.op == OP_PREFIX && cmd.a_hi == SUB_ERASE; // RL2
	assign do_ld_hi = exec && ok && cmd.op == OP_LOAD_HI; // RL5
	assign do_ld_lo = exec && ok && cmd.op == OP_LOAD_LO; // RL5
	assign do_ee_ld = exec && ok && cmd.op == OP_EE_LOAD; // RL7
	assign do_pg_wr = exec && ok && cmd.op == OP_PAGE_WR; // RL10
	assign do_ee_wr = exec && ok && cmd.op == OP_EE_WR; // RL11
	assign do_ee_pg = exec && ok && cmd.op == OP_EE_PAGE_WR; // RL11
	assign cfg_wr   = exec && ok && cmd.op == OP_PREFIX
		&& cmd.a_hi inside {SUB_WR_LOCK, SUB_WR_LFUSE, SUB_WR_HFUSE, SUB_WR_EFUSE}; // RL12

	// Response for byte four, built as byte three completes.
	always_comb
	begin
		resp = rx_in;
		case (b1_reg)
			OP_POLL:       resp = {7'h00, busy}; // RL3
			OP_RD_HI:      resp = flash[fa_rd[FA_W-1:0]][15:8]; // RL8
			OP_RD_LO:      resp = flash[fa_rd[FA_W-1:0]][7:0]; // RL8
			OP_EE_RD:      resp = eeprom[EA_W'({b2_reg, rx_in})]; // RL8
			OP_RD_LOCK_HF: resp = (b2_reg == SUB_HIGH) ? hf_reg : lock_reg; // RL9
			OP_RD_FUSE_EF: resp = (b2_reg == SUB_HIGH) ? ef_reg : lf_reg; // RL9
			OP_RD_SIG:
				case (rx_in[1:0]) // RL9
					2'h0:    resp = SIG0;
					2'h1:    resp = SIG1;
					2'h2:    resp = SIG2;
					default: resp = ERASED_BYTE;
				endcase
			OP_RD_CAL:     resp = CAL_BYTE; // RL9
			default:       resp = rx_in; // RL18
		endcase
	end

	always_comb
	begin
		bit_next  = bit_reg;
		byte_next = byte_reg;
		rx_next   = rx_reg;
		tx_next   = tx_reg;
		miso_next = miso_reg;
		en_next   = en_reg;
		b1_next   = b1_reg;
		b2_next   = b2_reg;
		b3_next   = b3_reg;
		ext_next  = ext_reg;
		lock_next = lock_reg;
		lf_next   = lf_reg;
		hf_next   = hf_reg;
		ef_next   = ef_reg;
		busy_next = busy ? busy_reg - 1'b1 : busy_reg;
		if (!hold)
		begin
			// Releasing the reset pin drops framing and the enable, so a retry starts clean.
			bit_next  = 3'h0;
			byte_next = 2'h0;
			en_next   = 1'b0;
			tx_next   = 8'h00;
			miso_next = 1'b0;
		end
		else if (sck_fall)
		begin
			miso_next = tx_reg[7]; // RL17
			tx_next   = {tx_reg[6:0], 1'b0};
		end
		else if (sck_rise)
		begin
			rx_next  = rx_in; // RL17
			bit_next = bit_reg + 3'h1;
			if (bit_reg == LAST_BIT)
			begin
				byte_next = byte_reg + 2'h1;
				tx_next   = rx_in; // RL18
				case (byte_reg)
					2'h0:    b1_next = rx_in;
					2'h1:    b2_next = rx_in;
					2'h2:
					begin
						b3_next = rx_in;
						tx_next = resp; // RL21
					end
					default: tx_next = rx_in;
				endcase
			end
		end
		if (exec && cmd.op == OP_PREFIX && cmd.a_hi == SUB_ENABLE)
			en_next = 1'b1; // RL1
		if (exec && ok)
			case (cmd.op)
				OP_EXT_ADDR: ext_next = cmd.a_lo; // RL4
				OP_PAGE_WR:  busy_next = BUSY_W'(FLASH_WAIT); // RL10
				OP_EE_WR, OP_EE_PAGE_WR: busy_next = BUSY_W'(EEPROM_WAIT); // RL11
				OP_PREFIX:
					case (cmd.a_hi) // RL12
						SUB_ERASE:
						begin
							busy_next = BUSY_W'(ERASE_WAIT);
							lock_next = CFG_RESET; // RL13
						end
						SUB_WR_LOCK:  lock_next = cmd.data;
						SUB_WR_LFUSE: lf_next   = cmd.data;
						SUB_WR_HFUSE: hf_next   = cmd.data;
						SUB_WR_EFUSE: ef_next   = cmd.data;
						default: busy_next = busy_next;
					endcase
				default: busy_next = busy_next;
			endcase
		if (cfg_wr)
			busy_next = BUSY_W'(FUSE_WAIT); // RL12
	end

	always_ff @(posedge CLK or negedge RST_N)
		if (!RST_N)
		begin
			bit_reg  <= 3'h0;
			byte_reg <= 2'h0;
			rx_reg   <= 8'h00;
			tx_reg   <= 8'h00;
			miso_reg <= 1'b0;
			en_reg   <= 1'b0;
			b1_reg   <= 8'h00;
			b2_reg   <= 8'h00;
			b3_reg   <= 8'h00;
			ext_reg  <= 8'h00;
			lock_reg <= CFG_RESET; // RL13
			lf_reg   <= CFG_RESET;
			hf_reg   <= CFG_RESET;
			ef_reg   <= CFG_RESET;
			busy_reg <= '0;
		end
		else if (CE)
		begin
			bit_reg  <= bit_next;
			byte_reg <= byte_next;
			rx_reg   <= rx_next;
			tx_reg   <= tx_next;
			miso_reg <= miso_next;
			en_reg   <= en_next;
			b1_reg   <= b1_next;
			b2_reg   <= b2_next;
			b3_reg   <= b3_next;
			ext_reg  <= ext_next;
			lock_reg <= lock_next;
			lf_reg   <= lf_next;
			hf_reg   <= hf_next;
			ef_reg   <= ef_next;
			busy_reg <= busy_next;
		end

	// Arrays carry no reset; whole-array loops keep erase and page commit to one cycle.
	always_ff @(posedge CLK)
		if (CE)
		begin
			if (do_erase)
			begin
				for (int i = 0; i < 2**FA_W; i++)
					flash[i] <= {ERASED_BYTE, ERASED_BYTE}; // RL20
				for (int i = 0; i < 2**EA_W; i++)
					eeprom[i] <= ERASED_BYTE; // RL20
			end
			if (do_ld_hi)
				pbuf[cmd.a_lo[FP_W-1:0]][15:8] <= cmd.data; // RL5
			if (do_ld_lo)
				pbuf[cmd.a_lo[FP_W-1:0]][7:0] <= cmd.data; // RL5
			if (do_pg_wr)
				for (int i = 0; i < 2**FP_W; i++)
					flash[{fa_cmd[FA_W-1:FP_W], FP_W'(i)}] <= pbuf[i]; // RL10
			if (do_ee_ld)
			begin
				ebuf[cmd.a_lo[EP_W-1:0]] <= cmd.data; // RL7
				evld[cmd.a_lo[EP_W-1:0]] <= 1'b1;
			end
			if (do_ee_wr)
				eeprom[ea_cmd[EA_W-1:0]] <= cmd.data; // RL20
			if (do_ee_pg)
			begin
				// Only slots loaded since the last commit are written.
				for (int i = 0; i < 2**EP_W; i++)
					if (evld[i])
						eeprom[{ea_cmd[EA_W-1:EP_W], EP_W'(i)}] <= ebuf[i]; // RL11
				evld <= '0;
			end
			if (!hold)
				evld <= '0;
		end

	assign MISO        = miso_reg;
	assign PROG_ACTIVE = en_reg;
	assign PENDING     = busy;

	default clocking dc @(posedge CLK); endclocking
	default disable iff (!RST_N);
	sequence s_enable_cmd;
		CE && exec && cmd.op == OP_PREFIX && cmd.a_hi == SUB_ENABLE;
	endsequence
	sequence s_erase_cmd;
		CE && do_erase;
	endsequence
	enable_entry_a: assert property (s_enable_cmd |=> en_reg) // RL1
		else $error("Enable instruction did not enable programming.");
	erase_busy_a: assert property (s_erase_cmd |=> busy_reg == BUSY_W'(ERASE_WAIT)) // RL2
		else $error("Chip erase did not start the erase wait.");
	erase_ones_a: assert property (s_erase_cmd |=> eeprom[0] == ERASED_BYTE && lock_reg == CFG_RESET) // RL20
		else $error("Chip erase left a location not all ones.");
	poll_resp_a: assert property (CE && hold && sck_rise && bit_reg == LAST_BIT
		&& byte_reg == ADDR_BYTE && b1_reg == OP_POLL |=> tx_reg == {7'h00, $past(busy)}) // RL3
		else $error("Poll response does not show the pending flag.");
	ext_latch_a: assert property (CE && exec && ok && cmd.op == OP_EXT_ADDR
		|=> ext_reg == $past(b3_reg)) // RL4
		else $error("Extended address byte not latched.");
	echo_byte_a: assert property (CE && hold && sck_rise && bit_reg == LAST_BIT
		&& byte_reg == 2'h1 |=> tx_reg == $past(rx_in)) // RL18
		else $error("Second byte is not echoed during the third.");
	fall_drive_a: assert property (CE && hold && sck_fall |=> miso_reg == $past(tx_reg[7])) // RL17
		else $error("Output bit not driven on the falling edge.");
	miso_stable_a: assert property (!sck_fall && hold ##1 hold |-> $stable(miso_reg)) // RL17
		else $error("Output bit changed away from a falling edge.");
	busy_count_a: assert property (CE && busy && !(exec && ok) |=> busy_reg == $past(busy_reg) - 1'b1)
		else $error("Pending counter did not count down.");
	cfg_write_a: assert property (CE && exec && ok && cmd.op == OP_PREFIX && cmd.a_hi == SUB_WR_HFUSE
		|=> hf_reg == $past(rx_in) ##1 busy) // RL12
		else $error("High fuse write not stored.");
endmodule // spd_serial_prog

// ### core/spd_pkg.sv
// Constants and types shared by the serial programming command decoder.
// Rules for this block and its programmer
// (RL1) Four-byte instructions; AC 53 00 00 enables programming.
// (RL2) AC 80 00 00 erases flash and EEPROM.
// (RL3) F0 poll returns pending flag in byte four.
// (RL4) 4D latches byte three as extended address.
// (RL5) 48/40 load page buffer high/low byte.
// (RL6) Programmer loads low byte before high byte.
// (RL7) C1 loads byte four into EEPROM page buffer.
// (RL8) 28/20/A0 return flash or EEPROM byte.
// (RL9) Lock, fuse, signature, calibration reads return byte.
// (RL10) 4C commits page buffer to addressed flash page.
// (RL11) C0 writes EEPROM byte; C2 commits EEPROM page.
// (RL12) AC E0/A0/A8/A4 write lock or fuse byte.
// (RL13) Zero bit programmed, one bit unprogrammed.
// (RL14) Programmer leaves unused fuse bits at one.
// (RL15) Programmer waits 4.5 or 9.0 ms unpolled.
// (RL16) Programmer issues EEPROM page write after loading.
// (RL17) Sample on rising, drive on falling serial clock.
// (RL18) Echo byte two while byte three shifts.
// (RL19) Programmer holds serial clock phases long enough.
// (RL20) EEPROM write self-erases; chip erase gives all ones.
// (RL21) MSB first; response shares byte four period.
package spd_pkg;
	localparam logic [7:0] OP_PREFIX     = 8'hac;
	localparam logic [7:0] SUB_ENABLE    = 8'h53;
	localparam logic [7:0] SUB_ERASE     = 8'h80;
	localparam logic [7:0] SUB_WR_LOCK   = 8'he0;
	localparam logic [7:0] SUB_WR_LFUSE  = 8'ha0;
	localparam logic [7:0] SUB_WR_HFUSE  = 8'ha8;
	localparam logic [7:0] SUB_WR_EFUSE  = 8'ha4;
	localparam logic [7:0] SUB_HIGH      = 8'h08;
	localparam logic [7:0] OP_POLL       = 8'hf0;
	localparam logic [7:0] OP_EXT_ADDR   = 8'h4d;
	localparam logic [7:0] OP_LOAD_HI    = 8'h48;
	localparam logic [7:0] OP_LOAD_LO    = 8'h40;
	localparam logic [7:0] OP_EE_LOAD    = 8'hc1;
	localparam logic [7:0] OP_RD_HI      = 8'h28;
	localparam logic [7:0] OP_RD_LO      = 8'h20;
	localparam logic [7:0] OP_EE_RD      = 8'ha0;
	localparam logic [7:0] OP_RD_LOCK_HF = 8'h58;
	localparam logic [7:0] OP_RD_FUSE_EF = 8'h50;
	localparam logic [7:0] OP_RD_SIG     = 8'h30;
	localparam logic [7:0] OP_RD_CAL     = 8'h38;
	localparam logic [7:0] OP_PAGE_WR    = 8'h4c;
	localparam logic [7:0] OP_EE_WR      = 8'hc0;
	localparam logic [7:0] OP_EE_PAGE_WR = 8'hc2;
	localparam logic [7:0] ERASED_BYTE   = 8'hff;
	localparam logic [7:0] CFG_RESET     = 8'hff;
	localparam logic [2:0] LAST_BIT      = 3'h7;
	localparam logic [1:0] LAST_BYTE     = 2'h3;
	localparam logic [1:0] ADDR_BYTE     = 2'h2;
	localparam int         CLK_KHZ       = 20000;
	localparam int         FUSE_WAIT_US  = 4500;
	localparam int         FLASH_WAIT_US = 4500;
	localparam int         EEPROM_WAIT_US = 9000;
	localparam int         ERASE_WAIT_US = 9000;
	localparam int         FUSE_WAIT_CYC  = (FUSE_WAIT_US * CLK_KHZ + 999) / 1000;
	localparam int         FLASH_WAIT_CYC = (FLASH_WAIT_US * CLK_KHZ + 999) / 1000;
	localparam int         EEPROM_WAIT_CYC = (EEPROM_WAIT_US * CLK_KHZ + 999) / 1000;
	localparam int         ERASE_WAIT_CYC = (ERASE_WAIT_US * CLK_KHZ + 999) / 1000;
	localparam int         BUSY_W        = 18;

	typedef struct packed {
		logic [7:0] op;
		logic [7:0] a_hi;
		logic [7:0] a_lo;
		logic [7:0] data;
	} spd_cmd_t;
endpackage

// ### testbench/spd_programmer.sv
// Programmer model that shifts four-byte instructions over the serial link.
`timescale 1ns/1ps
module spd_programmer
	import spd_pkg::*;
(
	output logic      sck,
	output logic      mosi,
	input  wire logic miso
);
	// Each phase lasts four system clocks, twice the least the input synchronisers accept.
	localparam time HALF = 200ns;

	initial
	begin
		sck  = 1'b0;
		mosi = 1'b0;
	end

	// The clock stands low between frames; a released data line shows the inverse level.
	task automatic xfer(input spd_cmd_t c, output spd_cmd_t r);
		logic [31:0] v;
		logic [31:0] w;
		v = c;
		#1ns;
		for (int i = 31; i >= 0; i--)
		begin
			mosi = v[i];
			#HALF sck = 1'b1;
			#(HALF - 10ns) w[i] = miso;
			#10ns sck = 1'b0;
		end
		mosi = ~mosi;
		r = w;
	endtask
endmodule // spd_programmer

// ### testbench/spd_serial_prog_tb.sv
// Self-checking bench for the serial programming command decoder.
`timescale 1ns/1ps
module spd_serial_prog_tb
	import spd_pkg::*;
	;
	localparam logic [15:0] FW = 16'h0014;
	localparam logic [15:0] EW = 16'h0028;
	localparam logic [15:0] UW = 16'h0014;
	localparam logic [15:0] XW = 16'h0258;
	localparam logic [7:0]  S0 = 8'h31; // Arbitrary value.
	localparam logic [7:0]  S1 = 8'h42; // Arbitrary value.
	localparam logic [7:0]  S2 = 8'h63; // Arbitrary value.
	localparam logic [7:0]  CB = 8'h6c;

	logic        clk;
	logic        rst_n;
	logic        ce;
	logic        rpin_n;
	logic        sck;
	logic        mosi;
	logic        miso;
	logic        prog_active;
	logic        pending;
	logic [7:0]  e3;
	logic [15:0] pend_cyc;
	int          n_mismatch;
	int          samples_checked;
	int          cyc;

	spd_serial_prog #(
		.SIG0(S0), .SIG1(S1), .SIG2(S2), .CAL_BYTE(CB),
		.FUSE_WAIT(UW), .FLASH_WAIT(FW), .EEPROM_WAIT(EW), .ERASE_WAIT(XW)
	) i_spd_serial_prog (
		.CLK(clk), .RST_N(rst_n), .CE(ce), .RESET_PIN_N(rpin_n), .SCK(sck),
		.MOSI(mosi), .MISO(miso), .PROG_ACTIVE(prog_active), .PENDING(pending)
	);

	spd_programmer i_spd_programmer (.sck(sck), .mosi(mosi), .miso(miso));

	initial
	begin
		clk = 1'b0;
		forever #25ns clk = ~clk;
	end

	always @(posedge clk)
	begin
		cyc++;
		if (pending === 1'b1)
			pend_cyc++;
		if (cyc == 40000)
		begin
			n_mismatch++;
			finish_test();
		end
	end

	task automatic check(input logic [15:0] s, input logic [15:0] e);
		samples_checked++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic op(input logic [7:0] a, b, c, d, output logic [7:0] r);
		spd_cmd_t q;
		@(posedge clk);
		i_spd_programmer.xfer('{a, b, c, d}, q);
		r  = q.data;
		e3 = q.a_lo;
	endtask

	task automatic rd(input logic [7:0] a, b, c, x);
		logic [7:0] r;
		op(a, b, c, 8'h00, r);
		check({8'h00, r}, {8'h00, x});
	endtask

	// Runs a write, lets its wait expire and checks how long the flag stood.
	task automatic wr(input logic [7:0] a, b, c, d, input logic [15:0] w);
		logic [7:0] r;
		pend_cyc = 16'h0000;
		op(a, b, c, d, r);
		repeat (w + 16'h0008) @(posedge clk);
		check(pend_cyc, w);
	endtask

	task automatic t_enable();
		logic [7:0] r;
		check({15'h0000, prog_active}, 16'h0000);
		op(8'hac, 8'h53, 8'h00, 8'h00, r);
		repeat (2) @(posedge clk);
		check({8'h00, e3}, 16'h0053);
		check({15'h0000, prog_active}, 16'h0001);
		$display("enable test ended");
	endtask

	task automatic t_erase();
		logic [7:0] r;
		pend_cyc = 16'h0000;
		op(8'hac, 8'h80, 8'h00, 8'h00, r);
		op(8'hf0, 8'h00, 8'h00, 8'h00, r);
		check({15'h0000, r[0]}, 16'h0001);
		repeat (XW) @(posedge clk);
		check(pend_cyc, XW);
		op(8'hf0, 8'h00, 8'h00, 8'h00, r);
		check({15'h0000, r[0]}, 16'h0000);
		rd(8'h20, 8'h00, 8'h05, 8'hff);
		rd(8'ha0, 8'h00, 8'h06, 8'hff);
		$display("erase test ended");
	endtask

	task automatic t_flash();
		logic [7:0] r;
		op(8'h4d, 8'h00, 8'h00, 8'h00, r);
		op(8'h40, 8'h00, 8'h05, 8'h3c, r);
		op(8'h48, 8'h00, 8'h05, 8'ha7, r);
		wr(8'h4c, 8'h00, 8'h00, 8'h00, FW);
		rd(8'h20, 8'h00, 8'h05, 8'h3c);
		rd(8'h28, 8'h00, 8'h05, 8'ha7);
		$display("flash test ended");
	endtask

	task automatic t_eeprom();
		logic [7:0] r;
		wr(8'hc0, 8'h00, 8'h12, 8'h5a, EW);
		rd(8'ha0, 8'h00, 8'h12, 8'h5a);
		op(8'hc1, 8'h00, 8'h00, 8'h11, r);
		op(8'hc1, 8'h00, 8'h01, 8'h22, r);
		wr(8'hc2, 8'h00, 8'h04, 8'h00, EW);
		rd(8'ha0, 8'h00, 8'h04, 8'h11);
		rd(8'ha0, 8'h00, 8'h05, 8'h22);
		rd(8'ha0, 8'h00, 8'h06, 8'hff);
		$display("eeprom test ended");
	endtask

	task automatic t_config();
		logic [7:0] sub [4] = '{8'he0, 8'ha0, 8'ha8, 8'ha4};
		logic [7:0] ro1 [4] = '{8'h58, 8'h50, 8'h58, 8'h50};
		logic [7:0] ro2 [4] = '{8'h00, 8'h00, 8'h08, 8'h08};
		logic [7:0] dat [4] = '{8'hfc, 8'he2, 8'hd9, 8'hfd};
		logic [7:0] sig [3] = '{S0, S1, S2};
		for (int i = 0; i < 4; i++)
		begin
			wr(8'hac, sub[i], 8'h00, dat[i], UW);
			rd(ro1[i], ro2[i], 8'h00, dat[i]);
		end
		for (int i = 0; i < 3; i++)
			rd(8'h30, 8'h00, 8'(i), sig[i]);
		rd(8'h38, 8'h00, 8'h00, CB);
		$display("config test ended");
	endtask

	// Leaving programming drops the mode; a write sent before a new enable must not land.
	task automatic t_exit();
		logic [7:0] r;
		@(posedge clk);
		#1 rpin_n = 1'b1;
		repeat (6) @(posedge clk);
		check({15'h0000, prog_active}, 16'h0000);
		#1 rpin_n = 1'b0;
		repeat (4) @(posedge clk);
		op(8'hc0, 8'h00, 8'h20, 8'h77, r);
		repeat (EW) @(posedge clk);
		op(8'hac, 8'h53, 8'h00, 8'h00, r);
		rd(8'ha0, 8'h00, 8'h20, 8'hff);
		$display("exit test ended");
	endtask

	task automatic finish_test();
		$display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial
	begin
		rst_n = 1'b0;
		ce = 1'b1;
		rpin_n = 1'b1;
		pend_cyc = 16'h0000;
		repeat (20) @(posedge clk);
		#1 rst_n = 1'b1;
		@(posedge clk);
		check({14'h0000, prog_active, pending}, 16'h0000);
		#1 rpin_n = 1'b0;
		repeat (4) @(posedge clk);
		t_enable();
		t_erase();
		t_flash();
		t_eeprom();
		t_config();
		t_exit();
		finish_test();
	end
endmodule // spd_serial_prog_tb
